// ### rtl/subsys_reset_consts.vh
// Constants for the subsystem reset pin block.
`ifndef SUBSYS_RESET_CONSTS_VH
`define SUBSYS_RESET_CONSTS_VH
`define WDOG_HOLD_CYCLES   10'h200
`define WDOG_CNT_WIDTH     10
`define COMM_VECTOR_ADDR   32'h00000004
`define CTRL_VECTOR_ADDR   22'h3FFFC0
`define CTRL_ADDR_WIDTH    22
`define SYNC_STAGES        3
`endif

// ### rtl/subsystem_reset_pins.v
// Reset pin handling for the digital and analog subsystems.
`timescale 1ns/100ps
`include "subsys_reset_consts.vh"

module subsystem_reset_pins (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        digital_por_active,
  input  wire        analog_por_active,
  input  wire        watchdog_reset,
  input  wire        digital_subsys_reset_n_in,
  output wire        digital_subsys_reset_n_out,
  output wire        digital_subsys_reset_n_oe,
  input  wire        analog_subsys_reset_n_in,
  output wire        analog_subsys_reset_n_out,
  output wire        analog_subsys_reset_n_oe,
  output reg         digital_reset_n,
  output reg         analog_logic_reset_n,
  output reg         cpu_halt,
  output reg         vector_fetch,
  output reg  [31:0] comm_vector_addr,
  output reg  [21:0] ctrl_vector_addr,
  output reg         cpu_run
);

  // One-hot codes for the release sequence of the two processors.
  localparam [2:0] ST_HOLD  = 3'h1;
  localparam [2:0] ST_FETCH = 3'h2;
  localparam [2:0] ST_RUN   = 3'h4;

  // Position of each pin in the pin vectors.
  localparam integer N_PINS  = 2;
  localparam integer PIN_DIG = 0;
  localparam integer PIN_ANA = 1;

  wire [N_PINS-1:0]           pin_level_in;
  wire [N_PINS-1:0]           pin_low;
  wire [N_PINS-1:0]           pin_drive;
  reg  [`WDOG_CNT_WIDTH-1:0]  wdog_cnt_reg;
  reg                         wdog_drive_reg;
  wire                        wdog_hold_next;
  reg                         dig_drive_reg;
  reg                         ana_drive_reg;
  wire                        dig_reset_any;
  wire                        ana_reset_any;
  reg  [2:0]                  state_reg;
  reg  [2:0]                  state_next;

  // Stages two and three of a synchroniser agree, so the sampled level is stable.
  function stages_agree;
    input [`SYNC_STAGES-1:0] stages;
    begin
      stages_agree = (stages[`SYNC_STAGES-1] == stages[`SYNC_STAGES-2]);
    end
  endfunction

  // The watchdog counter stands at its last cycle.
  function count_done;
    input [`WDOG_CNT_WIDTH-1:0] count;
    begin
      count_done = (count == {`WDOG_CNT_WIDTH{1'b0}});
    end
  endfunction

  // The pins are open drain: the output level is always low and the enable
  // is low only while this block pulls the pin down.
  assign digital_subsys_reset_n_out = 1'b0;
  assign analog_subsys_reset_n_out  = 1'b0;
  assign pin_drive                  = {ana_drive_reg, dig_drive_reg};
  assign digital_subsys_reset_n_oe  = ~pin_drive[PIN_DIG];
  assign analog_subsys_reset_n_oe   = ~pin_drive[PIN_ANA];

  assign pin_level_in = {analog_subsys_reset_n_in, digital_subsys_reset_n_in};

  // Three-stage synchronisers; a change counts once stages two and three agree.
  // The stages reset high, the idle level of the pulled-up pins, so that the
  // release of reset never looks like a falling pin.
  genvar g;

  generate
    for (g = 0; g < N_PINS; g = g + 1) begin : pin_sync
      reg [`SYNC_STAGES-1:0] stage_reg;
      reg                    low_reg;
      always @(posedge clock) begin
        if (!rst_n) begin
          stage_reg <= {`SYNC_STAGES{1'b1}};
          low_reg   <= 1'b0;
        end else begin
          stage_reg <= {stage_reg[`SYNC_STAGES-2:0], pin_level_in[g]};
          if (stages_agree(stage_reg)) begin
            low_reg <= ~stage_reg[`SYNC_STAGES-1];
          end
        end
      end
      assign pin_low[g] = low_reg;
    end
  endgenerate

  // Watchdog pulse stretcher. A watchdog event during a running pulse restarts
  // the count, so the pin is never released early.
  always @(posedge clock) begin
    if (!rst_n) begin
      wdog_cnt_reg   <= {`WDOG_CNT_WIDTH{1'b0}};
      wdog_drive_reg <= 1'b0;
    end else if (watchdog_reset) begin
      wdog_cnt_reg   <= `WDOG_HOLD_CYCLES - 10'h001;
      wdog_drive_reg <= 1'b1;
    end else if (wdog_drive_reg) begin
      if (count_done(wdog_cnt_reg)) begin
        wdog_drive_reg <= 1'b0;
      end else begin
        wdog_cnt_reg <= wdog_cnt_reg - 10'h001;
      end
    end
  end

  // The pin drive ends together with the last counted cycle, so the pin is
  // held for exactly the watchdog count and not one cycle longer.
  assign wdog_hold_next = watchdog_reset | (wdog_drive_reg & ~count_done(wdog_cnt_reg));

  // The sampled pin level already folds in external and own drive, but the
  // sources are also ORed in directly so reset is not delayed by the synchroniser.
  assign dig_reset_any = pin_low[PIN_DIG] | digital_por_active | watchdog_reset
                         | wdog_drive_reg;
  assign ana_reset_any = pin_low[PIN_ANA] | analog_por_active;

  // Own pull on each pin; both pins are pulled while the block is in reset.
  always @(posedge clock) begin
    if (!rst_n) begin
      dig_drive_reg <= 1'b1;
      ana_drive_reg <= 1'b1;
    end else begin
      dig_drive_reg <= digital_por_active | wdog_hold_next;
      ana_drive_reg <= analog_por_active;
    end
  end

  // Internal reset lines and the halt of execution.
  always @(posedge clock) begin
    if (!rst_n) begin
      digital_reset_n      <= 1'b0;
      analog_logic_reset_n <= 1'b0;
      cpu_halt             <= 1'b1;
    end else begin
      digital_reset_n      <= ~dig_reset_any;
      analog_logic_reset_n <= ~ana_reset_any;
      cpu_halt             <= dig_reset_any;
    end
  end

  // Start vector locations are fixed; they stand on the outputs at all times.
  always @(posedge clock) begin
    if (!rst_n) begin
      comm_vector_addr <= `COMM_VECTOR_ADDR;
      ctrl_vector_addr <= `CTRL_VECTOR_ADDR;
    end else begin
      comm_vector_addr <= `COMM_VECTOR_ADDR;
      ctrl_vector_addr <= `CTRL_VECTOR_ADDR;
    end
  end

  // Release sequence state.
  always @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Hold while any digital reset source is active, fetch vectors for one cycle, then run.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: begin
        if (!dig_reset_any) begin
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (dig_reset_any) begin
          state_next = ST_HOLD;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (dig_reset_any) begin
          state_next = ST_HOLD;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  // One-cycle pulse on release tells the cores to load their vectors; a new
  // reset during that cycle sends the sequence back to hold.
  always @(posedge clock) begin
    if (!rst_n) begin
      vector_fetch <= 1'b0;
      cpu_run      <= 1'b0;
    end else begin
      vector_fetch <= (state_next == ST_FETCH);
      cpu_run      <= (state_next == ST_RUN);
    end
  end

endmodule // subsystem_reset_pins

// ### test/reset_src_model.sv
// Outside open-drain reset source; the pin pull-up wins when nobody pulls.
`timescale 1ns/100ps
module reset_src_model (input wire pull_req, input wire dut_oe, output wire pin);
  assign pin = dut_oe & !pull_req;
endmodule // reset_src_model

// ### test/subsystem_reset_pins_assertions.sv
// Port checks for the subsystem reset pin block.
`timescale 1ns/100ps
module subsystem_reset_pins_assertions (input wire clock, rst_n, digital_por_active,
  analog_por_active, watchdog_reset, digital_subsys_reset_n_in, digital_subsys_reset_n_oe,
  analog_subsys_reset_n_in, analog_subsys_reset_n_oe, digital_reset_n, analog_logic_reset_n,
  cpu_halt, vector_fetch, cpu_run);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_hold; !digital_subsys_reset_n_oe ##300 !digital_subsys_reset_n_oe; endsequence
  sequence s_run; vector_fetch ##1 !vector_fetch && cpu_run; endsequence
  chk_por_pin: assert property (digital_por_active |=> !digital_subsys_reset_n_oe)
    else $error("por");
  chk_wdog_len: assert property (watchdog_reset |=> s_hold ##211
    !digital_subsys_reset_n_oe ##1 (digital_subsys_reset_n_oe || digital_por_active))
    else $error("wdog");
  chk_pin_reset: assert property ((!digital_subsys_reset_n_in)[*6]
    |-> !digital_reset_n) else $error("pin");
  chk_halt_run: assert property (!digital_reset_n |-> cpu_halt && !cpu_run)
    else $error("halt");
  chk_run_start: assert property ($rose(digital_reset_n) |-> s_run) else $error("run");
  chk_ana_por: assert property (analog_por_active |=> !analog_subsys_reset_n_oe)
    else $error("apor");
  chk_ana_pin: assert property ((!analog_subsys_reset_n_in)[*6]
    |-> !analog_logic_reset_n) else $error("apin");
  chk_any_src: assert property (digital_por_active || watchdog_reset
    |=> !digital_reset_n) else $error("src");
endmodule // subsystem_reset_pins_assertions
bind subsystem_reset_pins subsystem_reset_pins_assertions chk_inst (.*);

// ### test/subsystem_reset_pins_tb_top.sv
// Random and corner tests of the subsystem reset pin block.
`timescale 1ns/100ps
`include "subsys_reset_consts.vh"
module subsystem_reset_pins_tb_top;
  reg clock = 1'h0, rst_n = 1'h0, dp = 1'h0, ap = 1'h0, dq = 1'h0, aq = 1'h0, wd = 1'h0;
  reg [15:0] lfsr = 16'hA17F;
  wire di, doe, ai, aoe, dr, ar, hlt, vf, run, dout, aout;
  wire [31:0] cv;
  wire [21:0] tv;
  integer n_errors = 0, cmp_count = 0, i, s;
  always #12.5 clock = !clock;
  function [15:0] step(input [15:0] v); step = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]}; endfunction
  function en(input integer k, input a); en = (k % 2 == 1) != a; endfunction
  task check(input [31:0] seen, exp, input [47:0] nm); begin
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin n_errors = n_errors + 1; $display("ERROR %s %h %h", nm, exp, seen); end
  end endtask
  task tally_and_finish; begin
    $display("errors %0d checks %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end endtask
  reset_src_model reset_src_model_inst (.pull_req(dq), .dut_oe(doe), .pin(di));
  reset_src_model reset_src_model_a_inst (.pull_req(aq), .dut_oe(aoe), .pin(ai));
  subsystem_reset_pins subsystem_reset_pins_inst (.clock(clock), .rst_n(rst_n),
    .digital_por_active(dp), .analog_por_active(ap), .watchdog_reset(wd),
    .digital_subsys_reset_n_in(di), .digital_subsys_reset_n_out(dout),
    .digital_subsys_reset_n_oe(doe),
    .analog_subsys_reset_n_in(ai), .analog_subsys_reset_n_out(aout),
    .analog_subsys_reset_n_oe(aoe),
    .digital_reset_n(dr), .analog_logic_reset_n(ar), .cpu_halt(hlt), .vector_fetch(vf),
    .comm_vector_addr(cv), .ctrl_vector_addr(tv), .cpu_run(run));
  initial begin #500000; n_errors = n_errors + 1; tally_and_finish; end
  initial begin
    repeat (10) @(negedge clock);
    rst_n = 1'h1;
    for (i = 0; i < 12; i = i + 1) begin
      lfsr = step(lfsr);
      s = i < 5 ? i : lfsr % 5;
      {dp, ap, dq, aq, wd} = 5'h10 >> s;
      repeat (s == 4 ? 1 : 8 + lfsr[7:4]) @(negedge clock);
      wd = 1'h0;
      repeat (s == 4 ? 300 : 0) @(negedge clock);
      check({dr, hlt, doe, aoe, ar}, {en(s, 0), !en(s, 0), s % 4 != 0, s != 1, en(s, 1)}, "held");
      {dp, ap, dq, aq} = 4'h0;
      repeat (s == 4 ? 240 : 12) @(negedge clock);
      check({doe, aoe, dr, ar, hlt, run}, 6'h3D, "idle");
    end
    rst_n = 1'h0;
    repeat (3) @(negedge clock);
    check({doe, dr, hlt, run}, 4'h2, "reset");
    check({dout, aout}, 2'h0, "drvlvl");
    rst_n = 1'h1;
    repeat (12) @(negedge clock);
    check(cv, `COMM_VECTOR_ADDR, "comm");
    check({10'h000, tv}, `CTRL_VECTOR_ADDR, "ctrl");
    tally_and_finish;
  end
endmodule // subsystem_reset_pins_tb_top
